// file: core/usr_pkg.sv
// Shared constants and the state type for the universal shift register
package usr_pkg;
  localparam int STAGES = 4;
  localparam int FIFO_DEPTH = 4;
  localparam logic [STAGES-1:0] STAGE_RST = 4'h0;
  localparam logic MODE_SHIFT = 1'b0;
  localparam logic MODE_LOAD = 1'b1;
  localparam logic CLK_IDLE_RST = 1'b0;
  localparam int FIRST_STAGE = 0;

  typedef struct packed {
    logic [STAGES-1:0] stage;
    logic sclk_d;
    logic lclk_d;
    logic pend;
    logic [STAGES-1:0] pend_word;
  } usr_state_t;
endpackage

// file: core/usr_strm_if.sv
// Valid/ready word stream between the register core and its FIFO
interface usr_strm_if #(
  parameter int WIDTH = 4
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: core/usr_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module usr_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  usr_strm_if.snk wr,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } usr_fifo_st_t;

  usr_fifo_st_t st_r;
  usr_fifo_st_t st_nxt;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] usr_inc(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + AW'(1);
  endfunction

  assign wr.ready = ce && (st_r.cnt != CW'(DEPTH));
  assign rd_valid = ce && (st_r.cnt != '0);
  assign rd_data = st_r.mem[st_r.rp];
  assign push = wr.valid && wr.ready;
  assign pop = rd_valid && rd_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = wr.data;
      st_nxt.wp = usr_inc(st_r.wp);
    end
    if (pop) begin
      st_nxt.rp = usr_inc(st_r.rp);
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
endmodule

// file: core/usr_shift4.sv
// Four-stage universal shift register core with snapshot FIFO
// How it works
// R1: Four stages always visible on four parallel outputs, one per stage.
// R2: Mode low: shift right on shift-clock fall, serial bit enters first.
// R3: Mode low: load clock and parallel inputs have no effect.
// R4: Mode high: load-clock fall copies four parallel inputs into stages.
// R5: Stages change only on a falling clock edge or later from a held update, never on rising.
// R6: Outside logic wires outputs back for left shift in load mode.
// R7: Outside logic keeps data settled before the active clock edge.
// R8: Shift order first to last; last stage's old bit is dropped.
module usr_shift4 #(
  parameter int WIDTH = usr_pkg::STAGES,
  parameter int DEPTH = usr_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic mode_load,
  input wire logic shift_clk,
  input wire logic load_clk,
  input wire logic serial_shift_in,
  input wire logic [WIDTH-1:0] parallel_in,
  output logic [WIDTH-1:0] stage_out,
  output logic stage_first_out,
  output logic busy,
  output logic snap_valid,
  input wire logic snap_ready,
  output logic [WIDTH-1:0] snap_data
);
  usr_pkg::usr_state_t st_r;
  usr_pkg::usr_state_t st_nxt;
  logic sfall;
  logic lfall;
  logic ev;
  logic [WIDTH-1:0] ev_word;

  usr_strm_if #(.WIDTH(WIDTH)) push_if ();

  usr_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .wr(push_if),
    .rd_valid(snap_valid),
    .rd_ready(snap_ready),
    .rd_data(snap_data)
  );

  // Stages drive the outputs straight from flip-flops
  assign stage_out = st_r.stage; // [R1]
  assign stage_first_out = st_r.stage[usr_pkg::FIRST_STAGE];
  assign busy = st_r.pend;

  // Falling edges only
  assign sfall = st_r.sclk_d && !shift_clk; // [R5]
  assign lfall = st_r.lclk_d && !load_clk; // [R5]

  always_comb begin
    ev = 1'b0;
    ev_word = st_r.stage;
    if (mode_load == usr_pkg::MODE_SHIFT) begin
      // Load clock and parallel inputs ignored here
      ev = sfall; // [R3]
      ev_word = {st_r.stage[WIDTH-2:0], serial_shift_in}; // [R2] [R8]
    end else if (lfall) begin
      ev = 1'b1;
      ev_word = parallel_in; // [R4]
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_d = shift_clk;
    st_nxt.lclk_d = load_clk;
    push_if.valid = 1'b0;
    push_if.data = ev_word;
    if (st_r.pend) begin
      // Held update waits for FIFO room
      push_if.valid = ce;
      push_if.data = st_r.pend_word;
      if (push_if.ready) begin
        st_nxt.stage = st_r.pend_word;
        st_nxt.pend = 1'b0;
      end
    end else if (ev) begin
      push_if.valid = ce;
      if (push_if.ready) begin
        st_nxt.stage = ev_word; // [R2] [R4]
      end else begin
        st_nxt.pend = 1'b1;
        st_nxt.pend_word = ev_word;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r.stage <= usr_pkg::STAGE_RST;
      st_r.sclk_d <= usr_pkg::CLK_IDLE_RST;
      st_r.lclk_d <= usr_pkg::CLK_IDLE_RST;
      st_r.pend <= 1'b0;
      st_r.pend_word <= usr_pkg::STAGE_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  a_shift_right: assert property ( // [R2]
    @(posedge sys_clk) disable iff (rst)
    ce && !st_r.pend && mode_load == usr_pkg::MODE_SHIFT && sfall
      && push_if.ready
    |=> stage_out == {$past(stage_out[WIDTH-2:0]), $past(serial_shift_in)})
  else $error("shift right result wrong");

  a_last_drop: assert property ( // [R8]
    @(posedge sys_clk) disable iff (rst)
    ce && !st_r.pend && !mode_load && sfall && push_if.ready
    |=> stage_out[WIDTH-1] == $past(stage_out[WIDTH-2]))
  else $error("shift order wrong");

  a_load_copy: assert property ( // [R4]
    @(posedge sys_clk) disable iff (rst)
    ce && !st_r.pend && mode_load && lfall && push_if.ready
    |=> stage_out == $past(parallel_in))
  else $error("parallel load missed");

  a_shift_ignores: assert property ( // [R3]
    @(posedge sys_clk) disable iff (rst)
    ce && !st_r.pend && !mode_load && !sfall
    |=> $stable(stage_out))
  else $error("change without shift edge");

  a_rise_no_change: assert property ( // [R5]
    @(posedge sys_clk) disable iff (rst)
    ce && !st_r.pend && !sfall && !lfall
    |=> stage_out == $past(stage_out))
  else $error("stage moved on no falling edge");

  a_freeze_ce: assert property ( // [R1]
    @(posedge sys_clk) disable iff (rst)
    !ce |=> $stable(stage_out) && $stable(busy))
  else $error("state moved with enable low");

  a_pend_apply: assert property ( // [R5]
    @(posedge sys_clk) disable iff (rst)
    ce && st_r.pend && push_if.ready
    |=> stage_out == $past(st_r.pend_word) && !busy)
  else $error("held update not applied");

  a_snap_match: assert property ( // [R1]
    @(posedge sys_clk) disable iff (rst)
    push_if.valid && push_if.ready |=> stage_out == $past(push_if.data))
  else $error("snapshot differs from stages");
endmodule

// file: tb/usr_sink_model.sv
// Snapshot sink that stalls at random and on request
module usr_sink_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hold,
  output logic snap_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lfsr_r;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lfsr_r <= 8'h5a;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5]};
    end
    snap_ready <= !rst && !hold && lfsr_r[0];
  end
endmodule

// file: tb/usr_shift4_tb.sv
// Self-checking bench for the shift register with snapshot FIFO
module four_bit_universal_shift_register_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, ce = 1, mode_load = 0, shift_clk = 0;
  logic load_clk = 0, serial_shift_in = 0, hold = 0;
  logic stage_first_out, busy, snap_valid, snap_ready;
  logic [3:0] parallel_in = 4'h0, stage_out, snap_data, exp_r = 4'h0;
  logic [3:0] q[$];
  int fail_count = 0, samples_checked = 0;
  logic [31:0] rng = 32'hefa9;
  always #5 sys_clk = ~sys_clk;
  usr_shift4 usr_shift4_inst (.sys_clk, .rst, .ce, .mode_load, .shift_clk,
    .load_clk, .serial_shift_in, .parallel_in, .stage_out,
    .stage_first_out, .busy, .snap_valid, .snap_ready, .snap_data);
  usr_sink_model usr_sink_model_inst (.sys_clk, .rst, .hold, .snap_ready);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task chk(input string n, input logic [3:0] s, input logic [3:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task wait_clear(input bit all);
    int i;
    i = 0;
    while ((busy !== 1'b0 || (all && q.size() != 0)) && i < 300) begin
      @(posedge sys_clk);
      i++;
    end
    if (i == 300) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  task ev(input logic m, input logic c, input logic s, input logic [3:0] p);
    wait_clear(0);
    @(posedge sys_clk);
    mode_load <= m;
    serial_shift_in <= s;
    parallel_in <= p;
    if (c) load_clk <= 1'b1;
    else shift_clk <= 1'b1;
    rng = xs(rng);
    repeat (2 + rng[1:0]) @(posedge sys_clk);
    #1;
    chk("stage_rise", stage_out, exp_r);
    @(posedge sys_clk);
    shift_clk <= 1'b0;
    load_clk <= 1'b0;
    if (m == c) begin
      exp_r = m ? p : {exp_r[2:0], s};
      q.push_back(exp_r);
    end
    repeat (2) @(posedge sys_clk);
    #1;
    if (busy !== 1'b1) chk("stage_out", stage_out, exp_r);
    chk("stage_first_out", {3'h0, stage_first_out}, {3'h0, stage_out[0]});
  endtask
  always @(posedge sys_clk) begin
    if (!rst && snap_valid === 1'b1 && snap_ready === 1'b1) begin
      chk("snap_data", snap_data, q.size() ? q.pop_front() : 4'hx);
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("stage_rst", stage_out, 4'h0);
    chk("busy_rst", {3'h0, busy}, 4'h0);
    for (int k = 0; k < 28; k++) begin
      rng = xs(rng);
      ev(rng[0], rng[1], rng[2], rng[7:4]);
    end
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      ev(1'b1, 1'b1, 1'b0, {rng[0], exp_r[3:1]});
    end
    wait_clear(1);
    hold <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      ev(1'b0, 1'b0, k[0], 4'h0);
    end
    chk("busy_full", {3'h0, busy}, 4'h1);
    hold <= 1'b0;
    wait_clear(1);
    #1;
    chk("stage_held", stage_out, exp_r);
    report_and_stop;
  end
endmodule
